/* celpfa_top.sv */
// Speech frame analysis front end: input expansion, scheduling, excitation and synthesis
`timescale 1ns/1ns
`default_nettype none
module celpfa_top #(
  parameter int ORDER = celpfa_pkg::LP_ORDER,
  parameter int DEPTH = celpfa_pkg::HIST_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire celpfa_pkg::celpfa_fmt_t in_fmt,
  input wire logic [15:0] in_code,
  input wire celpfa_pkg::celpfa_mode_t mode_sel,
  output logic pcm_valid,
  output logic [15:0] pcm_sample,
  output logic [1:0] sub_idx,
  output celpfa_pkg::celpfa_cfg_t cfg,
  output celpfa_pkg::celpfa_sched_t sched,
  input wire logic [ORDER-1:0][15:0] ucoef,
  output logic wgt_valid,
  output logic [ORDER-1:0][15:0] wnum,
  output logic [ORDER-1:0][15:0] wden,
  input wire logic exc_valid,
  output logic exc_ready,
  input wire logic [15:0] fixed_cb,
  input wire logic [7:0] pitch_lag,
  input wire logic [15:0] pitch_gain,
  input wire logic [ORDER-1:0][15:0] qcoef,
  output logic [15:0] exc_out,
  output logic synth_valid,
  output logic [15:0] synth_sample
);
  // Schedule sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_LP0, ST_LP1, ST_LSPQ, ST_OLP, ST_TGT, ST_IMP, ST_CBK, ST_UPD
  } celpfa_state_t;

  // Mu-law code to left aligned linear word
  function automatic logic [15:0] ulaw_expand(input logic [7:0] c);
    logic [7:0] u;
    logic [15:0] t;
    logic [15:0] mag;
    u = ~c;
    t = ({9'h000, u[3:0], 3'b000} + celpfa_pkg::ULAW_BIAS) << u[6:4];
    mag = t - celpfa_pkg::ULAW_BIAS;
    ulaw_expand = (u[7] ? (16'h0000 - mag) : mag) & celpfa_pkg::LOW3_MASK;
  endfunction

  // A-law code to left aligned linear word
  function automatic logic [15:0] alaw_expand(input logic [7:0] c);
    logic [7:0] a;
    logic [15:0] t;
    a = c ^ celpfa_pkg::ALAW_XOR;
    t = {8'h00, a[3:0], 4'h0};
    if (a[6:4] == 3'h0) begin
      t = t + celpfa_pkg::ALAW_SEG0_ADD;
    end else begin
      t = (t + celpfa_pkg::ALAW_SEGN_ADD) << (a[6:4] - 3'h1);
    end
    alaw_expand = a[7] ? t : (16'h0000 - t);
  endfunction

  // Saturate a wide value to a 16-bit sample
  function automatic logic [15:0] sat16(input logic signed [39:0] v);
    if (v > 40'sd32767) begin
      sat16 = 16'h7fff;
    end else if (v < -40'sd32768) begin
      sat16 = 16'h8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  // Per-frame configuration of a mode
  function automatic celpfa_pkg::celpfa_cfg_t cfg_of(input celpfa_pkg::celpfa_mode_t m);
    cfg_of.mode = m;
    cfg_of.gamma1 = (m == celpfa_pkg::MODE_12K2 || m == celpfa_pkg::MODE_10K2) ?
                    celpfa_pkg::GAMMA1_HIGH_RATE : celpfa_pkg::GAMMA1_LOW_RATE;
    cfg_of.gamma2 = celpfa_pkg::GAMMA2_ALL;
    cfg_of.pitch_sixth = (m == celpfa_pkg::MODE_12K2);
    cfg_of.two_lp = (m == celpfa_pkg::MODE_12K2);
    cfg_of.split_matrix_quant = (m == celpfa_pkg::MODE_12K2);
    case (m)
      celpfa_pkg::MODE_12K2: cfg_of.lsp_bits = celpfa_pkg::LSP_BITS_MATRIX;
      celpfa_pkg::MODE_7K95: cfg_of.lsp_bits = celpfa_pkg::LSP_BITS_27;
      celpfa_pkg::MODE_5K15, celpfa_pkg::MODE_4K75: cfg_of.lsp_bits = celpfa_pkg::LSP_BITS_23;
      default: cfg_of.lsp_bits = celpfa_pkg::LSP_BITS_26;
    endcase
  endfunction

  // Sample counter, mode latch and input conversion state
  logic [7:0] cnt_reg, cnt_next;
  logic fs_reg, fs_next; // Frame start pulse
  logic ss_reg, ss_next; // Subframe start pulse
  celpfa_pkg::celpfa_cfg_t cfg_reg, cfg_next;
  logic pcm_valid_reg, pcm_valid_next;
  logic [15:0] pcm_reg, pcm_next;
  logic in_fire;
  celpfa_state_t state_reg, state_next;

  assign in_ready = (state_reg == ST_IDLE);
  assign in_fire = in_valid && in_ready;

  // Counter, mode latch and expansion next values
  always_comb begin
    cnt_next = cnt_reg;
    fs_next = 1'b0;
    ss_next = 1'b0;
    cfg_next = cfg_reg;
    pcm_valid_next = 1'b0;
    pcm_next = pcm_reg;
    if (in_fire) begin
      pcm_valid_next = 1'b1;
      case (in_fmt)
        celpfa_pkg::FMT_ALAW: pcm_next = alaw_expand(in_code[7:0]);
        celpfa_pkg::FMT_ULAW: pcm_next = ulaw_expand(in_code[7:0]);
        default: pcm_next = in_code & celpfa_pkg::LOW3_MASK;
      endcase
      cnt_next = (cnt_reg == 8'(celpfa_pkg::FRAME_LEN - 1)) ? celpfa_pkg::CNT_RESET :
                 cnt_reg + 8'h01;
      if (cnt_reg == celpfa_pkg::CNT_RESET) begin
        fs_next = 1'b1;
        cfg_next = cfg_of(mode_sel);
      end
      if (cnt_reg % 8'(celpfa_pkg::SUB_LEN) == 8'h00) begin
        ss_next = 1'b1;
      end
    end
  end

  // Counter, mode latch and expansion registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= celpfa_pkg::CNT_RESET;
      fs_reg <= 1'b0;
      ss_reg <= 1'b0;
      cfg_reg <= celpfa_pkg::CFG_RESET;
      pcm_valid_reg <= 1'b0;
      pcm_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_next;
      fs_reg <= fs_next;
      ss_reg <= ss_next;
      cfg_reg <= cfg_next;
      pcm_valid_reg <= pcm_valid_next;
      pcm_reg <= pcm_next;
    end
  end

  assign pcm_valid = pcm_valid_reg;
  assign pcm_sample = pcm_reg;
  assign cfg = cfg_reg;
  // Counter points past the last taken sample; zero means the frame's final sample
  assign sub_idx = (cnt_reg == celpfa_pkg::CNT_RESET) ? 2'h3 :
                   2'((cnt_reg - 8'h01) / 8'(celpfa_pkg::SUB_LEN));

  // Open-loop pitch due in this subframe
  logic olp_due;
  assign olp_due = (sub_idx == 2'h0) ||
                   (sub_idx == 2'h2 && cfg_reg.mode != celpfa_pkg::MODE_5K15 &&
                    cfg_reg.mode != celpfa_pkg::MODE_4K75);

  // Schedule sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (ss_reg) begin
          state_next = fs_reg ? ST_LP0 : (olp_due ? ST_OLP : ST_TGT);
        end
      end
      ST_LP0: state_next = cfg_reg.two_lp ? ST_LP1 : ST_LSPQ;
      ST_LP1: state_next = ST_LSPQ;
      ST_LSPQ: state_next = olp_due ? ST_OLP : ST_TGT;
      ST_OLP: state_next = ST_TGT;
      ST_TGT: state_next = ST_IMP;
      ST_IMP: state_next = ST_CBK;
      ST_CBK: state_next = ST_UPD;
      ST_UPD: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // Schedule sequencer register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Frame and subframe strobes from the counter pulses, step strobes decoded from the sequencer state
  assign sched.frame_start = fs_reg;
  assign sched.subframe_start = ss_reg;
  assign sched.lp_go = (state_reg == ST_LP0) || (state_reg == ST_LP1);
  assign sched.lp_set = (state_reg == ST_LP1);
  assign sched.lsp_go = (state_reg == ST_LSPQ);
  assign sched.olp_go = (state_reg == ST_OLP);
  assign sched.target_go = (state_reg == ST_TGT);
  assign sched.impulse_go = (state_reg == ST_IMP);
  assign sched.codebook_go = (state_reg == ST_CBK);
  assign sched.update_go = (state_reg == ST_UPD);

  // Weighting expansion state
  logic [3:0] wk_reg, wk_next; // Coefficient index, ORDER means idle
  logic [15:0] p1_reg, p1_next;
  logic [15:0] p2_reg, p2_next;
  logic [ORDER-1:0][15:0] wnum_reg, wnum_next;
  logic [ORDER-1:0][15:0] wden_reg, wden_next;
  logic wv_reg, wv_next;
  logic [31:0] p1_prod, p2_prod, n_prod, d_prod;

  assign p1_prod = p1_reg * cfg_reg.gamma1;
  assign p2_prod = p2_reg * cfg_reg.gamma2;
  assign n_prod = $signed(ucoef[wk_reg]) * $signed({1'b0, p1_prod[30:16]});
  assign d_prod = $signed(ucoef[wk_reg]) * $signed({1'b0, p2_prod[30:16]});

  // Bandwidth expansion next values
  always_comb begin
    wk_next = wk_reg;
    p1_next = p1_reg;
    p2_next = p2_reg;
    wnum_next = wnum_reg;
    wden_next = wden_reg;
    wv_next = 1'b0;
    if (state_reg == ST_LP0) begin
      wk_next = 4'h0;
      p1_next = celpfa_pkg::GAMMA_ONE;
      p2_next = celpfa_pkg::GAMMA_ONE;
    end else if (wk_reg < 4'(ORDER)) begin
      p1_next = {1'b0, p1_prod[29:15]};
      p2_next = {1'b0, p2_prod[29:15]};
      wnum_next[wk_reg] = n_prod[29:14];
      wden_next[wk_reg] = d_prod[29:14];
      wk_next = wk_reg + 4'h1;
      wv_next = (wk_reg == 4'(ORDER - 1));
    end
  end

  // Bandwidth expansion registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wk_reg <= 4'(ORDER);
      p1_reg <= 16'h0000;
      p2_reg <= 16'h0000;
      wnum_reg <= '0;
      wden_reg <= '0;
      wv_reg <= 1'b0;
    end else begin
      wk_reg <= wk_next;
      p1_reg <= p1_next;
      p2_reg <= p2_next;
      wnum_reg <= wnum_next;
      wden_reg <= wden_next;
      wv_reg <= wv_next;
    end
  end

  assign wnum = wnum_reg;
  assign wden = wden_reg;
  assign wgt_valid = wv_reg;

  // Excitation history and synthesis filter state
  logic [15:0] hist_reg [DEPTH], hist_next [DEPTH];
  logic [ORDER-1:0][15:0] ymem_reg, ymem_next;
  logic signed [39:0] acc_reg, acc_next;
  logic [3:0] tap_reg, tap_next; // ORDER means idle
  logic [15:0] exc_reg, exc_next;
  logic sv_reg, sv_next;
  logic [15:0] syn_reg, syn_next;
  logic exc_fire;
  logic [7:0] lag_idx;
  logic signed [31:0] adapt_prod, tap_prod;
  logic signed [39:0] exc_sum, acc_step;

  assign exc_ready = (tap_reg == 4'(ORDER));
  assign exc_fire = exc_valid && exc_ready;
  assign lag_idx = (pitch_lag == 8'h00) ? 8'h00 :
                   ((pitch_lag > 8'(DEPTH)) ? 8'(DEPTH - 1) : pitch_lag - 8'h01);
  assign adapt_prod = $signed(hist_reg[lag_idx]) * $signed(pitch_gain);
  assign exc_sum = 40'(adapt_prod >>> celpfa_pkg::GAIN_FRAC) + 40'($signed(fixed_cb));
  assign tap_prod = $signed(qcoef[tap_reg]) * $signed(ymem_reg[tap_reg]);
  assign acc_step = acc_reg - 40'(tap_prod);

  // Excitation and all-pole filter next values
  always_comb begin
    hist_next = hist_reg;
    ymem_next = ymem_reg;
    acc_next = acc_reg;
    tap_next = tap_reg;
    exc_next = exc_reg;
    sv_next = 1'b0;
    syn_next = syn_reg;
    if (exc_fire) begin
      exc_next = sat16(exc_sum);
      hist_next[0] = sat16(exc_sum);
      for (int i = 1; i < DEPTH; i++) begin
        hist_next[i] = hist_reg[i-1];
      end
      acc_next = 40'($signed(sat16(exc_sum))) <<< celpfa_pkg::COEF_FRAC;
      tap_next = 4'h0;
    end else if (tap_reg < 4'(ORDER)) begin
      acc_next = acc_step;
      tap_next = tap_reg + 4'h1;
      if (tap_reg == 4'(ORDER - 1)) begin
        ymem_next[0] = sat16(acc_step >>> celpfa_pkg::COEF_FRAC);
        for (int i = 1; i < ORDER; i++) begin
          ymem_next[i] = ymem_reg[i-1];
        end
        syn_next = sat16(acc_step >>> celpfa_pkg::COEF_FRAC) & celpfa_pkg::LOW3_MASK;
        sv_next = 1'b1;
      end
    end
  end

  // Excitation and all-pole filter registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        hist_reg[i] <= 16'h0000;
      end
      ymem_reg <= '0;
      acc_reg <= '0;
      tap_reg <= 4'(ORDER);
      exc_reg <= 16'h0000;
      sv_reg <= 1'b0;
      syn_reg <= 16'h0000;
    end else begin
      hist_reg <= hist_next;
      ymem_reg <= ymem_next;
      acc_reg <= acc_next;
      tap_reg <= tap_next;
      exc_reg <= exc_next;
      sv_reg <= sv_next;
      syn_reg <= syn_next;
    end
  end

  assign exc_out = exc_reg;
  assign synth_valid = sv_reg;
  assign synth_sample = syn_reg;

  // Checks on the schedule and datapath
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_FRAME_START: assert property (fs_reg |-> cnt_reg == 8'h01)
    else $error("frame start off the frame boundary");
  AST_SUB_START: assert property (ss_reg |-> cnt_reg % 8'h28 == 8'h01)
    else $error("subframe start off a 40 sample boundary");
  AST_MODE_HOLD: assert property (!fs_reg |-> $stable(cfg_reg))
    else $error("mode changed inside a frame");
  AST_TWO_LP: assert property (state_reg == ST_LP0 |=> sched.lp_go == cfg_reg.two_lp)
    else $error("wrong count of LP analyses");
  AST_LSP_KIND: assert property (sched.lsp_go |-> cfg_reg.split_matrix_quant ==
    (cfg_reg.mode == celpfa_pkg::MODE_12K2) && (!cfg_reg.split_matrix_quant ||
    cfg_reg.lsp_bits == 6'h26))
    else $error("wrong LSP quantizer kind");
  AST_GAMMA: assert property (cfg_reg.gamma2 == 16'h4ccd &&
    (cfg_reg.gamma1 == 16'h7333) ==
    (cfg_reg.mode == celpfa_pkg::MODE_12K2 || cfg_reg.mode == celpfa_pkg::MODE_10K2))
    else $error("wrong weighting factors");
  AST_OLP_SLOT: assert property (sched.olp_go |-> sub_idx == 2'h0 || (sub_idx == 2'h2 &&
    cfg_reg.mode != celpfa_pkg::MODE_5K15 && cfg_reg.mode != celpfa_pkg::MODE_4K75))
    else $error("open-loop pitch in wrong subframe");
  AST_IMP_FIRST: assert property (sched.codebook_go |->
    $past(sched.impulse_go) && $past(sched.target_go, 2))
    else $error("codebook search before impulse response");
  AST_CB_EACH_SUB: assert property (ss_reg |-> ##[3:7] sched.codebook_go)
    else $error("no codebook step in subframe");
  AST_PCM_FMT: assert property (pcm_valid |-> pcm_sample[2:0] == 3'b000)
    else $error("input sample low bits not zero");
  AST_SYN_TIME: assert property (exc_fire |-> ##11 synth_valid &&
    synth_sample[2:0] == 3'b000)
    else $error("synthesis output late or misformatted");
  AST_WGT_TIME: assert property (state_reg == ST_LP0 |-> ##11 wgt_valid)
    else $error("weighting coefficients late");

  COV_FRAME_TOP: cover property (fs_reg ##1 state_reg == ST_LP0 ##1 state_reg == ST_LP1);
  COV_FRAME_LOW: cover property (sched.lsp_go && cfg_reg.mode == celpfa_pkg::MODE_4K75);
  COV_SYNTH: cover property (exc_fire ##11 synth_valid);
endmodule
`default_nettype wire

/* celpfa_pkg.sv */
// Constants, modes and carrier types for the speech frame analysis front end
`default_nettype none
package celpfa_pkg;
  // Frame geometry derived from sample rate and frame time
  localparam int SAMPLE_RATE = 8000;
  localparam int FRAME_MS = 20;
  localparam int FRAME_LEN = SAMPLE_RATE * FRAME_MS / 1000;
  localparam int SUBS = 4;
  localparam int SUB_LEN = FRAME_LEN / SUBS;
  localparam int LP_ORDER = 10;
  localparam int COEF_FRAC = 12;
  localparam int GAIN_FRAC = 14;
  localparam int GAMMA_FRAC = 15;
  localparam int HIST_DEPTH = 160;
  localparam int SAMPLE_W = 16;
  // Weighting factors in Q15
  localparam logic [15:0] GAMMA1_HIGH_RATE = 16'h7333;
  localparam logic [15:0] GAMMA1_LOW_RATE = 16'h7852;
  localparam logic [15:0] GAMMA2_ALL = 16'h4ccd;
  localparam logic [15:0] GAMMA_ONE = 16'h7fff;
  // Line spectral pair bit budgets
  localparam logic [5:0] LSP_BITS_MATRIX = 6'h26;
  localparam logic [5:0] LSP_BITS_27 = 6'h1b;
  localparam logic [5:0] LSP_BITS_26 = 6'h1a;
  localparam logic [5:0] LSP_BITS_23 = 6'h17;
  // Sample format masks and companding offsets
  localparam logic [15:0] LOW3_MASK = 16'hfff8;
  localparam logic [15:0] ULAW_BIAS = 16'h0084;
  localparam logic [15:0] ALAW_SEG0_ADD = 16'h0008;
  localparam logic [15:0] ALAW_SEGN_ADD = 16'h0108;
  localparam logic [7:0] ALAW_XOR = 8'h55;
  localparam logic [7:0] CNT_RESET = 8'h00;

  // Rate modes, lowest rate first
  typedef enum logic [2:0] {
    MODE_4K75, MODE_5K15, MODE_5K90, MODE_6K70,
    MODE_7K40, MODE_7K95, MODE_10K2, MODE_12K2
  } celpfa_mode_t;

  // Input sample formats
  typedef enum logic [1:0] {FMT_LINEAR, FMT_ALAW, FMT_ULAW} celpfa_fmt_t;

  // Per-frame configuration derived from the latched mode
  typedef struct packed {
    celpfa_mode_t mode;
    logic [15:0] gamma1;
    logic [15:0] gamma2;
    logic pitch_sixth;
    logic two_lp;
    logic split_matrix_quant;
    logic [5:0] lsp_bits;
  } celpfa_cfg_t;

  // Schedule strobes towards the analysis engines
  typedef struct packed {
    logic frame_start;
    logic subframe_start;
    logic lp_go;
    logic lp_set;
    logic lsp_go;
    logic olp_go;
    logic target_go;
    logic impulse_go;
    logic codebook_go;
    logic update_go;
  } celpfa_sched_t;

  localparam celpfa_cfg_t CFG_RESET = '{MODE_12K2, GAMMA1_HIGH_RATE, GAMMA2_ALL,
                                        1'b1, 1'b1, 1'b1, LSP_BITS_MATRIX};
endpackage
`default_nettype wire

/* celpfa_src.sv */
// Speech sample source model that feeds the frame analysis input handshake
`timescale 1ns/1ns
`default_nettype none
module celpfa_src (
  input wire logic sys_clk,
  input wire logic in_ready,
  output logic in_valid,
  output celpfa_pkg::celpfa_fmt_t in_fmt,
  output logic [15:0] in_code
);
  // Ready level as it stood before the coming rising edge
  logic rdy_seen;

  // Idle line at time zero
  initial begin
    in_valid = 1'b0;
    in_fmt = celpfa_pkg::FMT_LINEAR;
    in_code = 16'h0000;
    rdy_seen = 1'b0;
  end

  // Ready is settled at the falling edge
  always @(negedge sys_clk) begin
    rdy_seen = in_ready;
  end

  // Offer one sample and hold it until taken; ok is low on a hang
  task automatic send(input celpfa_pkg::celpfa_fmt_t fmt, input logic [15:0] code,
                      output bit ok);
    int n;
    in_valid <= 1'b1;
    in_fmt <= fmt;
    // Linear: two's complement word, left aligned, low three bits clear; companded: code in the low byte
    in_code <= (fmt == celpfa_pkg::FMT_LINEAR) ? (code & celpfa_pkg::LOW3_MASK) :
               {8'h00, code[7:0]};
    ok = 1'b0;
    for (n = 0; n < 64 && !ok; n++) begin
      @(posedge sys_clk);
      ok = rdy_seen;
    end
  endtask

  // Release the line; stale data must not linger
  task automatic stop();
    in_valid <= 1'b0;
    in_code <= ~in_code;
  endtask
endmodule
`default_nettype wire

/* celpfa_tb.sv */
// Self-checking bench for the speech frame analysis front end
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // Design connections
  logic sys_clk, rst_n, in_valid, in_ready, pcm_valid, wgt_valid;
  logic exc_valid, exc_ready, synth_valid;
  celpfa_pkg::celpfa_fmt_t in_fmt;
  celpfa_pkg::celpfa_mode_t mode_sel;
  celpfa_pkg::celpfa_cfg_t cfg;
  celpfa_pkg::celpfa_sched_t sched;
  logic [15:0] in_code, pcm_sample, fixed_cb, pitch_gain, exc_out, synth_sample;
  logic [7:0] pitch_lag;
  logic [1:0] sub_idx;
  logic [celpfa_pkg::LP_ORDER-1:0][15:0] ucoef, qcoef, wnum, wden;
  // Bench state
  int num_errors, total_checks, m;
  int cnt [10];
  logic [15:0] exp_q [$];
  logic [15:0] wnum0, wden0;
  logic imp_seen, exc_rdy_seen;

  celpfa_top u_celpfa_top (.sys_clk(sys_clk), .rst_n(rst_n), .in_valid(in_valid),
    .in_ready(in_ready), .in_fmt(in_fmt), .in_code(in_code), .mode_sel(mode_sel),
    .pcm_valid(pcm_valid), .pcm_sample(pcm_sample), .sub_idx(sub_idx), .cfg(cfg),
    .sched(sched), .ucoef(ucoef), .wgt_valid(wgt_valid), .wnum(wnum), .wden(wden),
    .exc_valid(exc_valid), .exc_ready(exc_ready), .fixed_cb(fixed_cb),
    .pitch_lag(pitch_lag), .pitch_gain(pitch_gain), .qcoef(qcoef), .exc_out(exc_out),
    .synth_valid(synth_valid), .synth_sample(synth_sample));

  celpfa_src u_celpfa_src (.sys_clk(sys_clk), .in_ready(in_ready), .in_valid(in_valid),
    .in_fmt(in_fmt), .in_code(in_code));

  // 125 MHz clock
  initial sys_clk = 1'b0;
  always #4 sys_clk = ~sys_clk;

  // Count and report one comparison
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Counts, verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // A wait that ran out
  task automatic hang(input string what);
    num_errors++;
    $display("MISMATCH t=%0t %s never answered", $time, what);
    test_done();
  endtask

  // One sample through the source model
  task automatic tb_send(input celpfa_pkg::celpfa_fmt_t f, input logic [15:0] c);
    bit ok;
    u_celpfa_src.send(f, c, ok);
    if (!ok) begin
      hang("sample input");
    end
  endtask

  // Strobe counters and output sample watch, at settled falling edges
  always @(negedge sys_clk) begin
    cnt[0] += int'(sched.frame_start === 1'b1);
    cnt[1] += int'(sched.subframe_start === 1'b1);
    cnt[2] += int'(sched.lp_go === 1'b1);
    cnt[3] += int'(sched.olp_go === 1'b1);
    cnt[4] += int'(sched.target_go === 1'b1);
    cnt[5] += int'(sched.impulse_go === 1'b1);
    cnt[6] += int'(sched.codebook_go === 1'b1);
    cnt[7] += int'(sched.lp_set === 1'b1);
    cnt[8] += int'(sched.lsp_go === 1'b1);
    cnt[9] += int'(sched.update_go === 1'b1);
    // Subframe number follows the count of subframe starts since reset
    if (sched.subframe_start === 1'b1) begin
      imp_seen = 1'b0;
      check(16'(sub_idx), 16'((cnt[1] - 1) % 4), "sub idx");
    end
    if (sched.impulse_go === 1'b1) imp_seen = 1'b1;
    if (sched.codebook_go === 1'b1) begin
      check({15'h0000, imp_seen}, 16'h0001, "impulse first");
    end
    if (wgt_valid === 1'b1) begin
      wnum0 = wnum[0];
      wden0 = wden[0];
    end
    if (pcm_valid === 1'b1) begin
      check(pcm_sample, exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx, "pcm");
    end
    exc_rdy_seen = exc_ready;
  end

  // Expected quantizer bit budget per mode
  function automatic logic [5:0] exp_bits(input celpfa_pkg::celpfa_mode_t md);
    case (md)
      celpfa_pkg::MODE_12K2: exp_bits = celpfa_pkg::LSP_BITS_MATRIX;
      celpfa_pkg::MODE_7K95: exp_bits = celpfa_pkg::LSP_BITS_27;
      celpfa_pkg::MODE_5K15, celpfa_pkg::MODE_4K75: exp_bits = celpfa_pkg::LSP_BITS_23;
      default: exp_bits = celpfa_pkg::LSP_BITS_26;
    endcase
  endfunction

  // Idle outputs and ready handshakes after reset
  task automatic test_reset();
    check({15'h0000, cfg === celpfa_pkg::CFG_RESET}, 16'h0001, "reset cfg");
    check({14'h0000, in_ready, exc_ready}, 16'h0003, "ready");
    check({12'h000, pcm_valid, wgt_valid, synth_valid, sched.frame_start}, 16'h0000,
          "idle");
    $display("test reset done");
  endtask

  // One full frame in mode md, with the mode input moved after sample 0
  task automatic run_frame(input celpfa_pkg::celpfa_mode_t md);
    int base [10];
    int i;
    logic [15:0] code;
    logic top, high, low;
    base = cnt;
    top = (md == celpfa_pkg::MODE_12K2);
    high = top || (md == celpfa_pkg::MODE_10K2);
    low = (md == celpfa_pkg::MODE_5K15) || (md == celpfa_pkg::MODE_4K75);
    mode_sel <= md;
    for (i = 0; i < 160; i++) begin
      code = 16'h0107 + 16'(i * 211);
      exp_q.push_back(code & celpfa_pkg::LOW3_MASK);
      tb_send(celpfa_pkg::FMT_LINEAR, code);
      if (i == 0) mode_sel <= celpfa_pkg::celpfa_mode_t'(~md);
    end
    // Drop valid so the last sample is not taken a second time
    u_celpfa_src.stop();
    @(negedge sys_clk);
    check(16'(cfg.mode), 16'(md), "mode");
    check(cfg.gamma1, high ? celpfa_pkg::GAMMA1_HIGH_RATE : celpfa_pkg::GAMMA1_LOW_RATE,
          "g1");
    check(cfg.gamma2, celpfa_pkg::GAMMA2_ALL, "g2");
    check(16'(cfg.two_lp), 16'(top), "two lp");
    check(16'(cfg.split_matrix_quant), 16'(top), "matrix");
    check(16'(cfg.pitch_sixth), 16'(top), "sixth");
    check(16'(cfg.lsp_bits), 16'(exp_bits(md)), "lsp bits");
    check(wnum0, high ? 16'h0e66 : 16'h0f0a, "weighting");
    check(wden0, 16'h0999, "weighting den");
    check(16'(cnt[7] - base[7]), top ? 16'h0001 : 16'h0000, "lp second set");
    check(16'(cnt[8] - base[8]), 16'h0001, "lsp runs");
    check(16'(cnt[9] - base[9]), 16'h0004, "updates");
    check(16'(cnt[0] - base[0]), 16'h0001, "frames");
    check(16'(cnt[1] - base[1]), 16'h0004, "subframes");
    check(16'(cnt[2] - base[2]), top ? 16'h0002 : 16'h0001, "lp runs");
    check(16'(cnt[3] - base[3]), low ? 16'h0001 : 16'h0002, "open loop");
    check(16'(cnt[4] - base[4]), 16'h0004, "target");
    check(16'(cnt[5] - base[5]), 16'h0004, "impulse");
    check(16'(cnt[6] - base[6]), 16'h0004, "codebook");
    $display("test frame mode %0d done", md);
    @(posedge sys_clk);
  endtask

  // Companded codes, A-law first, then mu-law
  task automatic test_companded();
    logic [23:0] tab [7];
    int i;
    tab = '{24'hd5_0008, 24'h55_fff8, 24'haa_7e00, 24'h2a_8200,
            24'hff_0000, 24'h80_7d78, 24'h00_8280};
    for (i = 0; i < 7; i++) begin
      exp_q.push_back(tab[i][15:0]);
      tb_send(i < 4 ? celpfa_pkg::FMT_ALAW : celpfa_pkg::FMT_ULAW, {8'h00, tab[i][23:16]});
    end
    u_celpfa_src.stop();
    // Second falling edge so the watcher has popped the last sample
    repeat (2) @(negedge sys_clk);
    check(16'(exp_q.size()), 16'h0000, "all out");
    $display("test companded done");
  endtask

  // One excitation sample through the filter with its expected result
  task automatic exc_push(input logic [15:0] fx, input logic [7:0] lag, input logic [15:0] gain,
                          input logic [15:0] ex);
    int n;
    @(posedge sys_clk);
    fixed_cb <= fx;
    pitch_lag <= lag;
    pitch_gain <= gain;
    exc_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (exc_rdy_seen !== 1'b1 && n < 64);
    if (exc_rdy_seen !== 1'b1) hang("excitation");
    exc_valid <= 1'b0;
    fixed_cb <= ~fx;
    @(negedge sys_clk);
    check(exc_out, ex, "excitation");
    n = 1;
    while (synth_valid !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    check(16'(n), 16'h000b, "synth latency");
    check(synth_sample, ex & celpfa_pkg::LOW3_MASK, "synth");
  endtask

  // Fixed only, pitch of newest, older lag, then saturation
  task automatic test_excitation();
    exc_push(16'h1000, 8'h01, 16'h0000, 16'h1000);
    exc_push(16'h0200, 8'h01, 16'h4000, 16'h1200);
    exc_push(16'h0000, 8'h02, 16'h4000, 16'h1000);
    exc_push(16'h7000, 8'h01, 16'h4000, 16'h7fff);
    $display("test excitation done");
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    mode_sel = celpfa_pkg::MODE_12K2;
    ucoef = '0;
    ucoef[0] = 16'h1000;
    qcoef = '0;
    exc_valid = 1'b0;
    fixed_cb = 16'h0000;
    pitch_lag = 8'h01;
    pitch_gain = 16'h0000;
    num_errors = 0;
    total_checks = 0;
    imp_seen = 1'b0;
    exc_rdy_seen = 1'b0;
    wnum0 = 16'h0000;
    wden0 = 16'h0000;
    cnt = '{default: 0};
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    test_reset();
    @(posedge sys_clk);
    for (m = 7; m >= 0; m--) begin
      run_frame(celpfa_pkg::celpfa_mode_t'(m));
    end
    test_companded();
    test_excitation();
    test_done();
  end
endmodule
`default_nettype wire
